// [hvs_sequencer.sv]
// haptic/vibrate mode control and H-bridge phase sequencer
// assumes reset_n is the device reset pin; register bits arrive on clk
//
// Operation
// - both inputs and repeat bit low: standby, bridge undriven
// - vibrate alone drives bridge forward
// - haptic level in sequence, vibrate level otherwise
// - vibrate input ignored when reset or disabled
// - trigger input ignored when reset or disabled
// - trigger edge runs forward, coast, reverse
// - coast releases both outputs with timer start
// - two microsecond dead gap on reversal
// - recovery phase blocks new triggers
// - trigger overrides vibrate, vibrate resumes after
// - internal or external time base select
// - divide time base up to 128
// - external clock watchdog aborts sequence
// - reset pin clears everything and shuts down
// - reset low rejects programming and operation
// - disabled: programming allowed, no operation
// - repeat bit loops sequence regardless of inputs
// - phase durations from four timing fields
// - forward, coast, reverse last twice field
// - recovery lasts four times field
// - ratio is product of three divider bits
`timescale 1ns/10ps
`include "hvs_defines.svh"
module hvs_sequencer
   import hvs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = `HVS_TICK_CYCLES,
   parameter int unsigned WDOG_CYCLES = `HVS_WDOG_CYCLES
)(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       device_enable,
   input  wire logic       vibrate_enable_pin,
   input  wire logic       vibrate_enable_reg,
   input  wire logic       haptic_trigger_pin,
   input  wire logic       haptic_trigger_reg,
   input  wire logic       sequence_repeat,
   input  wire logic       external_timebase_select,
   input  wire logic       timebase_input,
   input  wire logic       div2_enable,
   input  wire logic       div4_enable,
   input  wire logic       div16_enable,
   input  wire logic [3:0] forward_timer,
   input  wire logic [3:0] coast_timer,
   input  wire logic [3:0] reverse_timer,
   input  wire logic [3:0] recovery_timer,
   input  wire logic [4:0] haptic_level_setting,
   input  wire logic [4:0] vibrate_level_setting,
   output logic            motor_plus_out,
   output logic            motor_plus_oe,
   output logic            motor_minus_out,
   output logic            motor_minus_oe,
   output logic            regulator_on,
   output logic [4:0]      regulator_setting,
   output logic            sequence_active,
   output logic            program_allow
);

   localparam logic [8:0] DEAD_LOAD = 9'(`HVS_DEAD_CYCLES - 1);

   logic [2:0]    pins_s;
   logic          osc_s;
   logic          trig_s;
   logic          vib_s;
   logic          osc_prev_ff;
   logic          trig_prev_ff;
   logic          ext_rise;
   logic          tick;
   logic          wd_expired;
   logic          enabled;
   logic          vib_active;
   logic          trig_level;
   logic          trig_rise;
   logic          start;
   logic          adv;
   logic [7:0]    ratio;
   hvs_state_type state_ff;
   hvs_state_type nxt_state;
   hvs_state_type dead_to_ff;
   hvs_state_type nxt_dead_to;
   hvs_state_type go;
   hvs_state_type done_st;
   hvs_state_type after_rec;
   hvs_state_type after_rev;
   hvs_state_type after_coast;
   hvs_state_type first;
   logic [5:0]    phase_cnt_ff;
   logic [5:0]    nxt_phase_cnt;
   logic [8:0]    dead_cnt_ff;

   // pins pass two flops before use
   hvs_sync2 #(
      .WIDTH (3)
   ) u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .async_in ({timebase_input, haptic_trigger_pin, vibrate_enable_pin}),
      .sync_ff  (pins_s)
   );

   assign osc_s  = pins_s[2];
   assign trig_s = pins_s[1];
   assign vib_s  = pins_s[0];

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_prev_ff  <= 1'b0;
         trig_prev_ff <= 1'b0;
      end else begin
         osc_prev_ff  <= osc_s;
         trig_prev_ff <= trig_level;
      end
   end

   assign ext_rise = osc_s && !osc_prev_ff;

   assign ratio = hvs_div_ratio(div2_enable, div4_enable, div16_enable);

   hvs_timebase #(
      .TICK_CYCLES (TICK_CYCLES),
      .WDOG_CYCLES (WDOG_CYCLES)
   ) u_timebase (
      .clk           (clk),
      .reset_n       (reset_n),
      .ext_sel       (external_timebase_select),
      .ext_rise      (ext_rise),
      .ratio         (ratio),
      .tick_ff       (tick),
      .wd_expired_ff (wd_expired)
   );

   assign enabled    = device_enable;
   assign vib_active = enabled && (vib_s || vibrate_enable_reg);
   assign trig_level = trig_s || haptic_trigger_reg;
   assign trig_rise  = enabled && trig_level && !trig_prev_ff;
   assign start      = enabled && (trig_rise || sequence_repeat);
   assign adv        = tick && (phase_cnt_ff == 6'h01);

   always_comb begin
      done_st     = (vib_active && !sequence_repeat) ? HVS_VIB : HVS_IDLE;
      after_rec   = (recovery_timer != 4'h0) ? HVS_RECOV : done_st;
      after_rev   = (reverse_timer != 4'h0) ? HVS_REV : after_rec;
      after_coast = (coast_timer != 4'h0) ? HVS_COAST : after_rev;
      first       = (forward_timer != 4'h0) ? HVS_FWD : after_coast;
   end

   always_comb begin
      go = state_ff;
      unique case (state_ff)
         // idle or vibrate, new trigger only here
         HVS_IDLE, HVS_VIB: go = start ? first : done_st;
         HVS_FWD:   if (adv) go = after_coast;
         HVS_COAST: if (adv) go = after_rev;
         HVS_REV:   if (adv) go = after_rec;
         HVS_RECOV: if (adv) go = done_st;
         HVS_DEAD:  if (dead_cnt_ff == 9'h000) go = dead_to_ff;
         default:   go = HVS_IDLE;
      endcase
      if (!enabled) begin
         go = HVS_IDLE;
      end else if (wd_expired && (state_ff inside {HVS_FWD, HVS_COAST, HVS_REV, HVS_RECOV})) begin
         go = done_st;
      end
   end

   // reversals pass through the dead gap
   always_comb begin
      nxt_dead_to = dead_to_ff;
      nxt_state   = go;
      if ((hvs_is_fwd(state_ff) && hvs_is_rev(go)) ||
          (hvs_is_rev(state_ff) && hvs_is_fwd(go))) begin
         nxt_state   = HVS_DEAD;
         nxt_dead_to = go;
      end
   end

   always_comb begin
      nxt_phase_cnt = phase_cnt_ff;
      if (nxt_state != state_ff) begin
         unique case (nxt_state)
            HVS_FWD:   nxt_phase_cnt = {1'b0, forward_timer, 1'b0};
            HVS_COAST: nxt_phase_cnt = {1'b0, coast_timer, 1'b0};
            HVS_REV:   nxt_phase_cnt = {1'b0, reverse_timer, 1'b0};
            HVS_RECOV: nxt_phase_cnt = {recovery_timer, 2'b00};
            default:   nxt_phase_cnt = 6'h00;
         endcase
      end else if (tick && (phase_cnt_ff != 6'h00)) begin
         nxt_phase_cnt = phase_cnt_ff - 6'h01;
      end
   end

   // reset pin returns all state to defaults
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff     <= HVS_IDLE;
         dead_to_ff   <= HVS_IDLE;
         phase_cnt_ff <= 6'h00;
      end else begin
         state_ff     <= nxt_state;
         dead_to_ff   <= nxt_dead_to;
         phase_cnt_ff <= nxt_phase_cnt;
      end
   end

   // dead gap counter in clock cycles
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         dead_cnt_ff <= 9'h000;
      end else if ((nxt_state == HVS_DEAD) && (state_ff != HVS_DEAD)) begin
         dead_cnt_ff <= DEAD_LOAD;
      end else if (dead_cnt_ff != 9'h000) begin
         dead_cnt_ff <= dead_cnt_ff - 9'h001;
      end
   end

   // bridge drive follows the state in the same edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         motor_plus_out  <= 1'b0;
         motor_plus_oe   <= 1'b0;
         motor_minus_out <= 1'b0;
         motor_minus_oe  <= 1'b0;
      end else begin
         motor_plus_out  <= hvs_is_fwd(nxt_state);
         motor_plus_oe   <= hvs_is_fwd(nxt_state) || hvs_is_rev(nxt_state);
         motor_minus_out <= hvs_is_rev(nxt_state);
         motor_minus_oe  <= hvs_is_fwd(nxt_state) || hvs_is_rev(nxt_state);
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         regulator_on      <= 1'b0;
         regulator_setting <= `HVS_LEVEL_RESET;
         sequence_active   <= 1'b0;
      end else begin
         regulator_on    <= nxt_state != HVS_IDLE;
         sequence_active <= hvs_is_seq(nxt_state, nxt_dead_to);
         if (hvs_is_seq(nxt_state, nxt_dead_to)) begin
            regulator_setting <= haptic_level_setting;
         end else begin
            regulator_setting <= vibrate_level_setting;
         end
      end
   end

   // programming refused while reset is low
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         program_allow <= 1'b0;
      end else begin
         program_allow <= 1'b1;
      end
   end

   a_standby_undriven: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_ff == HVS_IDLE |-> !motor_plus_oe && !motor_minus_oe)
      else $error("bridge driven in standby");

   a_vib_forward: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_ff == HVS_VIB |-> motor_plus_oe && motor_plus_out &&
                              motor_minus_oe && !motor_minus_out)
      else $error("vibrate not forward");

   a_level_vib: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_ff == HVS_VIB |-> regulator_setting == $past(vibrate_level_setting))
      else $error("vibrate level not applied");

   a_disable_idle: assert property (
      @(posedge clk) disable iff (!reset_n)
      !device_enable |=> state_ff == HVS_IDLE && !motor_plus_oe)
      else $error("operation while disabled");

   a_coast_release: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_ff == HVS_COAST |-> !motor_plus_oe && !motor_minus_oe)
      else $error("bridge driven in coast");

   a_no_shoot: assert property (
      @(posedge clk) disable iff (!reset_n)
      hvs_is_fwd(state_ff) |=> !hvs_is_rev(state_ff))
      else $error("reversal without dead gap");

   a_dead_length: assert property (
      @(posedge clk) disable iff (!reset_n)
      $rose(state_ff == HVS_DEAD) && device_enable
      |-> dead_cnt_ff == DEAD_LOAD)
      else $error("dead gap length wrong");

   a_recov_hold: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_ff == HVS_RECOV && phase_cnt_ff > 6'h01 && device_enable && !wd_expired
      |=> state_ff == HVS_RECOV)
      else $error("recovery left early");

   a_wdog_abort: assert property (
      @(posedge clk) disable iff (!reset_n)
      wd_expired && (state_ff inside {HVS_FWD, HVS_REV})
      |=> !(state_ff inside {HVS_FWD, HVS_COAST, HVS_REV, HVS_RECOV}))
      else $error("watchdog did not abort");

   a_fwd_length: assert property (
      @(posedge clk) disable iff (!reset_n)
      state_ff == HVS_FWD && $past(state_ff) != HVS_FWD
      |-> phase_cnt_ff == {1'b0, $past(forward_timer), 1'b0})
      else $error("forward length wrong");

   a_skip_zero: assert property (
      @(posedge clk) disable iff (!reset_n)
      (state_ff inside {HVS_FWD, HVS_COAST, HVS_RECOV}) |-> phase_cnt_ff != 6'h00)
      else $error("zero length phase entered");

endmodule

// [hvs_defines.svh]
// timing constants for the haptic/vibrate sequencer
// assumes a 200 MHz core clock
`ifndef HVS_DEFINES_SVH
`define HVS_DEFINES_SVH

`define HVS_CLK_PERIOD_NS    5
`define HVS_TICK_PERIOD_NS   1000000
`define HVS_TICK_CYCLES      (`HVS_TICK_PERIOD_NS / `HVS_CLK_PERIOD_NS)
`define HVS_DEAD_NS          2000
`define HVS_DEAD_CYCLES      ((`HVS_DEAD_NS + `HVS_CLK_PERIOD_NS - 1) / `HVS_CLK_PERIOD_NS)
`define HVS_WDOG_NS          8000000
`define HVS_WDOG_CYCLES      (`HVS_WDOG_NS / `HVS_CLK_PERIOD_NS)
`define HVS_LEVEL_RESET      5'h00
`define HVS_DIV_MAX          8'h80

`endif

// [hvs_pkg.sv]
// types and helper functions of the haptic/vibrate sequencer
// assumes nothing beyond a SystemVerilog compiler
package hvs_pkg;

   typedef enum logic [2:0] {
      HVS_IDLE  = 3'h0,
      HVS_FWD   = 3'h1,
      HVS_COAST = 3'h3,
      HVS_DEAD  = 3'h2,
      HVS_REV   = 3'h6,
      HVS_RECOV = 3'h7,
      HVS_VIB   = 3'h4
   } hvs_state_type;

   // product of the three divider enables, 1 to 128
   function automatic logic [7:0] hvs_div_ratio(input logic d2,
                                                input logic d4,
                                                input logic d16);
      logic [7:0] r;
      r = 8'h01;
      if (d2)  r = {r[6:0], 1'b0};
      if (d4)  r = {r[5:0], 2'b00};
      if (d16) r = {r[3:0], 4'h0};
      return r;
   endfunction

   function automatic logic hvs_is_fwd(input hvs_state_type s);
      return (s == HVS_FWD) || (s == HVS_VIB);
   endfunction

   function automatic logic hvs_is_rev(input hvs_state_type s);
      return s == HVS_REV;
   endfunction

   // haptic level applies for sequence phases and gaps leading into them
   function automatic logic hvs_is_seq(input hvs_state_type s,
                                       input hvs_state_type to);
      return (s == HVS_FWD) || (s == HVS_COAST) || (s == HVS_REV) ||
             (s == HVS_RECOV) ||
             ((s == HVS_DEAD) && (to != HVS_VIB) && (to != HVS_IDLE));
   endfunction

endpackage

// [hvs_sync2.sv]
// two-flop synchroniser for asynchronous pins
// assumes inputs come from outside the clk domain
`timescale 1ns/10ps
module hvs_sync2
   import hvs_pkg::*;
#(
   parameter int WIDTH = 1
)(
   input  wire logic             clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_ff
);

   logic [WIDTH-1:0] meta_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_ff <= '0;
         sync_ff <= '0;
      end else begin
         meta_ff <= async_in;
         sync_ff <= meta_ff;
      end
   end

endmodule

// [hvs_timebase.sv]
// time base select, divider and external clock watchdog
// assumes ext_rise is a one-cycle pulse already synchronised to clk
`timescale 1ns/10ps
module hvs_timebase
   import hvs_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = 200000,
   parameter int unsigned WDOG_CYCLES = 1600000
)(
   input  wire logic       clk,
   input  wire logic       reset_n,
   input  wire logic       ext_sel,
   input  wire logic       ext_rise,
   input  wire logic [7:0] ratio,
   output logic            tick_ff,
   output logic            wd_expired_ff
);

   logic [17:0] int_cnt_ff;
   logic        int_tick;
   logic        src_tick;
   logic [6:0]  div_cnt_ff;
   logic [20:0] wd_cnt_ff;

   // internal 1 ms reference
   assign int_tick = (int_cnt_ff == 18'(TICK_CYCLES - 1));
   assign src_tick = ext_sel ? ext_rise : int_tick;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         int_cnt_ff <= 18'h0_0000;
      end else if (int_tick) begin
         int_cnt_ff <= 18'h0_0000;
      end else begin
         int_cnt_ff <= int_cnt_ff + 18'h0_0001;
      end
   end

   // divide selected source by ratio
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_ff <= 7'h00;
         tick_ff    <= 1'b0;
      end else begin
         tick_ff <= 1'b0;
         if (src_tick) begin
            if ({1'b0, div_cnt_ff} >= (ratio - 8'h01)) begin
               div_cnt_ff <= 7'h00;
               tick_ff    <= 1'b1;
            end else begin
               div_cnt_ff <= div_cnt_ff + 7'h01;
            end
         end
      end
   end

   // rising-to-rising interval watchdog on the external input
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wd_cnt_ff     <= 21'h00_0000;
         wd_expired_ff <= 1'b0;
      end else begin
         if (!ext_sel || ext_rise) begin
            wd_cnt_ff <= 21'h00_0000;
         end else if (wd_cnt_ff != 21'(WDOG_CYCLES)) begin
            wd_cnt_ff <= wd_cnt_ff + 21'h00_0001;
         end
         wd_expired_ff <= ext_sel && !ext_rise && (wd_cnt_ff >= 21'(WDOG_CYCLES - 1));
      end
   end

endmodule

// [hvs_motor_model.sv]
// motor across the bridge outputs, reports the drive it sees
// assumes oe high means that bridge side is driven
`timescale 1ns/10ps
module hvs_motor_model (
   input  wire logic       clk,
   input  wire logic       plus_out,
   input  wire logic       plus_oe,
   input  wire logic       minus_out,
   input  wire logic       minus_oe,
   output logic            plus_wire,
   output logic            minus_wire,
   output logic [1:0]      drive
);
   logic plus_last_ff  = 1'b0;
   logic minus_last_ff = 1'b0;
   // released terminal floats, so show a changing level
   always @(posedge clk) begin
      plus_last_ff  <= plus_wire;
      minus_last_ff <= minus_wire;
   end
   assign plus_wire  = plus_oe ? plus_out : ~plus_last_ff;
   assign minus_wire = minus_oe ? minus_out : ~minus_last_ff;
   // direction: 1 forward, 2 reverse, 0 free, 3 fault
   always_comb begin
      if (!plus_oe && !minus_oe) drive = 2'h0;
      else if (plus_oe && minus_oe && plus_out && !minus_out) drive = 2'h1;
      else if (plus_oe && minus_oe && !plus_out && minus_out) drive = 2'h2;
      else drive = 2'h3;
   end
endmodule

// [tb_haptic_vibrate_mode_sequencer.sv]
// self-checking bench for the haptic/vibrate sequencer
// assumes shortened tick and watchdog parameters
`timescale 1ns/10ps
module tb_haptic_vibrate_mode_sequencer;
   import hvs_pkg::*;
   localparam int unsigned TICK = 20;
   localparam int unsigned WDOG = 200;
   logic       clk, reset_n, dev_en, vib_pin, vib_reg, trig_pin, trig_reg, rept;
   logic       ext_sel, tb_in, d2, d4, d16, r2, r4;
   logic [3:0] fwd_t, cst_t, rev_t, rec_t;
   logic [4:0] hap_lvl, vib_lvl, reg_set;
   logic       plus_out, plus_oe, minus_out, minus_oe, reg_on, seq_act, prog_ok;
   logic       plus_wire, minus_wire;
   logic [1:0] drive;
   int         miscompares, compares, seed, ext_half, ext_cnt, i, per;

   hvs_sequencer #(.TICK_CYCLES(TICK), .WDOG_CYCLES(WDOG)) DUT (
      .clk(clk), .reset_n(reset_n), .device_enable(dev_en),
      .vibrate_enable_pin(vib_pin), .vibrate_enable_reg(vib_reg),
      .haptic_trigger_pin(trig_pin), .haptic_trigger_reg(trig_reg),
      .sequence_repeat(rept), .external_timebase_select(ext_sel),
      .timebase_input(tb_in), .div2_enable(d2), .div4_enable(d4), .div16_enable(d16),
      .forward_timer(fwd_t), .coast_timer(cst_t), .reverse_timer(rev_t),
      .recovery_timer(rec_t), .haptic_level_setting(hap_lvl),
      .vibrate_level_setting(vib_lvl), .motor_plus_out(plus_out),
      .motor_plus_oe(plus_oe), .motor_minus_out(minus_out), .motor_minus_oe(minus_oe),
      .regulator_on(reg_on), .regulator_setting(reg_set), .sequence_active(seq_act),
      .program_allow(prog_ok));

   hvs_motor_model motor (
      .clk(clk), .plus_out(plus_out), .plus_oe(plus_oe), .minus_out(minus_out),
      .minus_oe(minus_oe), .plus_wire(plus_wire), .minus_wire(minus_wire), .drive(drive));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // external oscillator, stopped while ext_half is zero
   always @(posedge clk) begin
      if (ext_half != 0) begin
         ext_cnt <= (ext_cnt + 1 >= ext_half) ? 0 : ext_cnt + 1;
         if (ext_cnt + 1 >= ext_half) tb_in <= ~tb_in;
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic final_report();
      if (miscompares == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   function automatic int ratio_of(input logic a, input logic b, input logic c);
      return (a ? 2 : 1) * (b ? 4 : 1) * (c ? 16 : 1);
   endfunction

   // phase of n divided ticks, first tick may come early
   function automatic logic in_rng(input int len, input int n, input int p);
      if (n == 0) return len <= 3;
      return (len > (n - 1) * p - 3) && (len <= n * p + 3);
   endfunction

   task automatic set_trig(input logic pin, input logic v);
      @(posedge clk);
      if (pin) trig_pin <= v;
      else trig_reg <= v;
   endtask

   task automatic wait_seq(input logic v, input int lim, input string name);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (seq_act !== v && n < lim);
      check(name, seq_act, v);
   endtask

   task automatic measure(input logic [1:0] st, output int len);
      len = 0;
      while (drive === st && len < 20000) begin
         @(negedge clk);
         len++;
      end
   endtask

   task automatic haptic_run(input logic vib, input logic pin, input int p);
      int len;
      if (vib) begin
         @(posedge clk);
         if (pin) vib_reg <= 1'b1;
         else vib_pin <= 1'b1;
         repeat (8) @(negedge clk);
         check("vib_drive", drive, 2'h1);
         check("vib_level", reg_set, vib_lvl);
         check("vib_wire", {plus_wire, minus_wire}, 2'h2);
      end
      set_trig(pin, 1'b1);
      wait_seq(1'b1, 12, "seq_start");
      check("hap_level", reg_set, hap_lvl);
      set_trig(pin, 1'b0);
      set_trig(pin, 1'b1);
      measure(2'h1, len);
      check("fwd_len", in_rng(len + 2, 2 * fwd_t, p), 1'b1);
      measure(2'h0, len);
      check("gap_len", (cst_t == 0) ? ((len >= 399) && (len <= 402)) :
            in_rng(len, 2 * cst_t, p), 1'b1);
      check("rev_drive", drive, 2'h2);
      measure(2'h2, len);
      check("rev_len", in_rng(len, 2 * rev_t, p), 1'b1);
      if (vib) begin
         measure(2'h0, len);
         check("dead_back", (rec_t == 0) ? ((len >= 399) && (len <= 402)) :
               in_rng(len, 4 * rec_t, p), 1'b1);
         check("vib_back", {drive, reg_set}, {2'h1, vib_lvl});
      end else begin
         if (rec_t != 0) begin
            set_trig(pin, 1'b0);
            set_trig(pin, 1'b1);
         end
         len = 0;
         while (seq_act === 1'b1 && len < 20000) begin
            @(negedge clk);
            len++;
         end
         check("rec_len", in_rng(len + 2 * (rec_t != 0), 4 * rec_t, p), 1'b1);
         check("idle_after", {plus_oe, minus_oe, reg_on}, 3'h0);
      end
      repeat (40) @(negedge clk);
      check("no_requeue", seq_act, 1'b0);
      set_trig(pin, 1'b0);
      vib_pin <= 1'b0;
      vib_reg <= 1'b0;
      repeat (420) @(posedge clk);
   endtask

   initial begin
      #(5ns * 100000);
      miscompares++;
      final_report();
   end

   initial begin
      seed = 54;
      {miscompares, compares, ext_half, ext_cnt} = '0;
      {reset_n, vib_pin, vib_reg, trig_pin, trig_reg, rept, ext_sel, tb_in} = 8'h00;
      {d2, d4, d16, fwd_t, cst_t, rev_t, rec_t} = '0;
      dev_en = 1'b1;
      hap_lvl = 5'($random(seed));
      vib_lvl = 5'($random(seed));
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (3) @(negedge clk);
      check("standby", {plus_oe, minus_oe, reg_on, seq_act}, 4'h0);
      check("prog_ok", prog_ok, 1'b1);
      @(posedge clk);
      dev_en <= 1'b0;
      vib_reg <= 1'b1;
      trig_reg <= 1'b1;
      repeat (20) @(negedge clk);
      check("disabled", {plus_oe, minus_oe, reg_on, seq_act, prog_ok}, 5'h01);
      @(posedge clk);
      {dev_en, vib_reg, trig_reg} <= 3'h4;
      for (i = 0; i < 6; i++) begin
         r2 = $random(seed);
         r4 = $random(seed);
         per = TICK * ratio_of(r2 | (i == 5), r4 | (i == 5), i == 5);
         @(posedge clk);
         {d2, d4, d16} <= {r2 | (i == 5), r4 | (i == 5), i == 5};
         fwd_t <= (i == 5) ? 4'h1 : ({2'h0, 2'($random(seed))} | 4'h1);
         rev_t <= (i == 5) ? 4'h1 : ({2'h0, 2'($random(seed))} | 4'h1);
         cst_t <= (i == 5) ? 4'h0 : {2'h0, 2'($random(seed))};
         rec_t <= (i == 5) ? 4'h0 : {2'h0, 2'($random(seed))};
         haptic_run(i[0], 1'($random(seed)), per);
      end
      // external time base, divided by two
      @(posedge clk);
      {ext_sel, d2, d4, d16} <= 4'hc;
      ext_half <= 15;
      {fwd_t, cst_t, rev_t, rec_t} <= 16'h2111;
      repeat (10) @(posedge clk);
      haptic_run(1'b0, 1'b0, 60);
      @(posedge clk);
      fwd_t <= 4'hf;
      d2 <= 1'b0;
      set_trig(1'b0, 1'b1);
      wait_seq(1'b1, 12, "wd_start");
      @(posedge clk);
      ext_half <= 0;
      wait_seq(1'b0, WDOG + 80, "wd_abort");
      set_trig(1'b0, 1'b0);
      ext_sel <= 1'b0;
      repeat (420) @(posedge clk);
      {fwd_t, cst_t, rev_t, rec_t} <= 16'h1011;
      rept <= 1'b1;
      wait_seq(1'b1, 60, "rpt_start");
      wait_seq(1'b0, 2000, "rpt_end");
      wait_seq(1'b1, 5, "rpt_again");
      @(posedge clk);
      reset_n <= 1'b0;
      @(negedge clk);
      check("in_reset", {plus_oe, minus_oe, reg_on, seq_act, prog_ok, reg_set}, 10'h000);
      @(posedge clk);
      rept <= 1'b0;
      reset_n <= 1'b1;
      repeat (3) @(negedge clk);
      check("after_reset", {prog_ok, seq_act, plus_oe}, 3'h4);
      final_report();
   end
endmodule
